// *** core/mth_regs.svh ***
`ifndef MTH_REGS_SVH
`define MTH_REGS_SVH

// link word offsets
`define MTH_W_TASK_FIRST 5'h02
`define MTH_W_TASK_LAST  5'h09
`define MTH_W_VAR0       5'h10
`define MTH_W_VAR1       5'h11
`define MTH_W_STOPOVER   5'h12
`define MTH_W_STATUS     5'h13

// task control word bits
`define MTH_B_AUTO  1
`define MTH_B_START 2
`define MTH_B_READ  7

// program block fields
`define MTH_F_OP_HI   31
`define MTH_F_OP_LO   28
`define MTH_F_AUX_EN  27
`define MTH_F_NTF_EN  26
`define MTH_F_REP_HI  25
`define MTH_F_REP_LO  18
`define MTH_F_USE_V1  16

// apb byte offsets
`define MTH_A_LINK_ADDR 8'h00
`define MTH_A_LINK_DATA 8'h04
`define MTH_A_STATUS    8'h08
`define MTH_A_AUX_ACK   8'h0C
`define MTH_A_OPT_IN    8'h10
`define MTH_A_IRQ_STAT  8'h14
`define MTH_A_IRQ_MASK  8'h18
`define MTH_A_NOTIFY    8'h1C

// interrupt status bits
`define MTH_I_AUX     0
`define MTH_I_NOTIFY  1
`define MTH_I_REFUSED 2
`define MTH_I_DONE    3
`define MTH_I_W       4

`define MTH_RST_WORD 16'h0000

`endif

// *** core/mth_pkg.sv ***
package mth_pkg;

    typedef enum logic [3:0] {
        MTH_OP_END    = 4'h0,
        MTH_OP_LINEAR = 4'h1,
        MTH_OP_CIRC   = 4'h2,
        MTH_OP_HELIX  = 4'h3,
        MTH_OP_WAIT   = 4'h4,
        MTH_OP_JUMP   = 4'h5,
        MTH_OP_PARAM  = 4'h6
    } mth_op_e;

    typedef enum logic [2:0] {
        MTH_ST_IDLE  = 3'h0,
        MTH_ST_FETCH = 3'h1,
        MTH_ST_EXEC  = 3'h3,
        MTH_ST_MOVE  = 3'h2,
        MTH_ST_AUX   = 3'h6
    } mth_state_e;

endpackage

// *** core/mth_link_if.sv ***
`timescale 1ns/10ps
interface mth_link_if;
    logic        wr_en;
    logic [4:0]  addr;
    logic [15:0] wr_data;
    logic [15:0] rd_data;
    logic        busy;
    logic [1:0]  task_id;
    logic        aux_strobe;
    logic [15:0] aux_code;
    logic        aux_reset;
    logic        opt_in0;
    logic        notify;
    logic [15:0] notify_num;

    modport dev (
        input  wr_en, addr, wr_data, aux_reset, opt_in0,
        output rd_data, busy, task_id, aux_strobe, aux_code, notify, notify_num
    );
    modport host (
        output wr_en, addr, wr_data, aux_reset, opt_in0,
        input  rd_data, busy, task_id, aux_strobe, aux_code, notify, notify_num
    );
endinterface

// *** core/mth_device.sv ***
// Local design decision: the link device that fetches and runs the task programs.
`timescale 1ns/10ps
`include "mth_regs.svh"
module mth_device #(
    parameter int PROG_AW = 8,
    parameter int STEP_W  = 4
) (
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               ce,
    mth_link_if.dev                 link,
    input  wire logic               prog_we,
    input  wire logic [PROG_AW-1:0] prog_addr,
    input  wire logic [31:0]        prog_wdata,
    input  wire logic               move_ready,
    input  wire logic               move_done,
    input  wire logic [15:0]        present_pos,
    output logic                    move_start,
    output mth_pkg::mth_op_e        move_kind,
    output logic [15:0]             move_target,
    output logic                    gain_set,
    output logic [3:0]              gain_axis,
    output logic [7:0]              gain_pct,
    output logic [3:0]              auto_mode
);

    logic [31:0]          mem [2**PROG_AW];
    logic [15:0]          sel_q [4];
    logic [15:0]          ctl_q [4];
    logic [15:0]          progn_q [4];
    logic [3:0]           prog_ok_q;
    logic [3:0]           rd_prev_q;
    logic [3:0]           st_prev_q;
    logic [3:0]           rd_evt;
    logic [3:0]           st_evt;
    logic [15:0]          var0_q;
    logic [15:0]          var1_q;
    logic [15:0]          stop_q;
    mth_pkg::mth_state_e  state_q;
    logic [PROG_AW-1:0]   pc_q;
    logic [31:0]          blk_q;
    logic [7:0]           rep_q;
    logic [1:0]           task_q;
    logic [15:0]          prev_tgt_q;
    logic                 armed_q;
    logic [15:0]          thr_q;
    logic [15:0]          ntf_num_q;
    logic                 notify_q;
    logic                 aux_q;
    logic [15:0]          aux_code_q;
    logic [15:0]          rd_data_q;
    logic                 move_start_q;
    mth_pkg::mth_op_e     move_kind_q;
    logic [15:0]          move_tgt_q;
    logic                 gain_set_q;
    logic [3:0]           gain_axis_q;
    logic [7:0]           gain_pct_q;

    wire mth_pkg::mth_op_e op       = mth_pkg::mth_op_e'(blk_q[`MTH_F_OP_HI:`MTH_F_OP_LO]);
    wire                   aux_en   = blk_q[`MTH_F_AUX_EN];
    wire                   ntf_en   = blk_q[`MTH_F_NTF_EN];
    wire [15:0]            code     = blk_q[15:0];
    wire [15:0]            tgt      = blk_q[`MTH_F_USE_V1] ? var1_q : var0_q;
    wire                   is_move  = (op == mth_pkg::MTH_OP_LINEAR) ||
                                      (op == mth_pkg::MTH_OP_CIRC) ||
                                      (op == mth_pkg::MTH_OP_HELIX);
    wire                   issue    = (state_q == mth_pkg::MTH_ST_EXEC) && is_move && move_ready;
    wire [PROG_AW-1:0]     pc_inc   = pc_q + PROG_AW'(1);
    wire [PROG_AW-1:0]     pc_skip  = pc_q + PROG_AW'(2);
    // start arbitration: lowest task wins, starts while busy are dropped
    wire [1:0]         st_task  = st_evt[0] ? 2'h0 : st_evt[1] ? 2'h1 : st_evt[2] ? 2'h2 : 2'h3;
    wire [15:0]        st_prog  = progn_q[st_task];
    wire [PROG_AW-1:0] st_base  = {st_prog[PROG_AW-STEP_W-1:0], {STEP_W{1'b0}}};
    wire [PROG_AW-1:0] jmp_pc   = {pc_q[PROG_AW-1:STEP_W], code[STEP_W-1:0]};
    wire        rd_task  = (link.addr >= `MTH_W_TASK_FIRST) && (link.addr <= `MTH_W_TASK_LAST);
    wire [2:0]  rd_pair  = link.addr[3:1] - 3'h1;
    wire [1:0]  rd_t     = rd_pair[1:0];
    wire [15:0] rd_tword = link.addr[0] ? ctl_q[rd_t] : sel_q[rd_t];
    wire [15:0] status_w = {13'h0000, state_q != mth_pkg::MTH_ST_IDLE, task_q};
    wire [15:0] rd_mux   = rd_task                        ? rd_tword :
                           (link.addr == `MTH_W_VAR0)     ? var0_q :
                           (link.addr == `MTH_W_VAR1)     ? var1_q :
                           (link.addr == `MTH_W_STOPOVER) ? stop_q :
                           (link.addr == `MTH_W_STATUS)   ? status_w : 16'h0000;
    genvar t;
    generate
        for (t = 0; t < 4; t++) begin : g_task
            localparam logic [4:0] SEL_W = 5'(`MTH_W_TASK_FIRST + 2 * t);
            localparam logic [4:0] CTL_W = 5'(`MTH_W_TASK_FIRST + 2 * t + 1);
            wire wr_sel = link.wr_en && (link.addr == SEL_W);
            wire wr_ctl = link.wr_en && (link.addr == CTL_W);
            assign rd_evt[t] = ctl_q[t][`MTH_B_READ] & ~rd_prev_q[t];
            assign st_evt[t] = ctl_q[t][`MTH_B_START] & ~st_prev_q[t]
                             & ctl_q[t][`MTH_B_AUTO] & prog_ok_q[t];
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    sel_q[t]     <= `MTH_RST_WORD;
                    ctl_q[t]     <= `MTH_RST_WORD;
                    progn_q[t]   <= `MTH_RST_WORD;
                    prog_ok_q[t] <= 1'b0;
                    rd_prev_q[t] <= 1'b0;
                    st_prev_q[t] <= 1'b0;
                end else if (ce) begin
                    if (wr_sel) begin
                        sel_q[t] <= link.wr_data;
                    end
                    if (wr_ctl) begin
                        ctl_q[t] <= link.wr_data;
                    end
                    rd_prev_q[t] <= ctl_q[t][`MTH_B_READ];
                    st_prev_q[t] <= ctl_q[t][`MTH_B_START];
                    if (rd_evt[t]) begin
                        progn_q[t]   <= sel_q[t];
                        prog_ok_q[t] <= 1'b1;
                    end
                end
            end
        end
    endgenerate
    always_ff @(posedge pclk) begin
        if (ce && prog_we) begin
            mem[prog_addr] <= prog_wdata;
        end
    end
    // host variables and stopover distance, visible to the next block at once
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            var0_q    <= `MTH_RST_WORD;
            var1_q    <= `MTH_RST_WORD;
            stop_q    <= `MTH_RST_WORD;
            rd_data_q <= `MTH_RST_WORD;
        end else if (ce) begin
            if (link.wr_en && link.addr == `MTH_W_VAR0) begin
                var0_q <= link.wr_data;
            end
            if (link.wr_en && link.addr == `MTH_W_VAR1) begin
                var1_q <= link.wr_data;
            end
            if (link.wr_en && link.addr == `MTH_W_STOPOVER) begin
                stop_q <= link.wr_data;
            end
            rd_data_q <= rd_mux;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q    <= mth_pkg::MTH_ST_IDLE;
            pc_q       <= '0;
            blk_q      <= 32'h00000000;
            rep_q      <= 8'h00;
            task_q     <= 2'h0;
            aux_q      <= 1'b0;
            aux_code_q <= `MTH_RST_WORD;
        end else if (ce) begin
            unique case (state_q)
                mth_pkg::MTH_ST_IDLE: begin
                    if (|st_evt) begin
                        pc_q    <= st_base;
                        task_q  <= st_task;
                        state_q <= mth_pkg::MTH_ST_FETCH;
                    end
                end
                mth_pkg::MTH_ST_FETCH: begin
                    blk_q   <= mem[pc_q];
                    rep_q   <= mem[pc_q][`MTH_F_REP_HI:`MTH_F_REP_LO];
                    state_q <= mth_pkg::MTH_ST_EXEC;
                end
                mth_pkg::MTH_ST_EXEC: begin
                    if (op == mth_pkg::MTH_OP_END) begin
                        state_q <= mth_pkg::MTH_ST_IDLE;
                    end else if (op == mth_pkg::MTH_OP_JUMP) begin
                        pc_q    <= jmp_pc;
                        state_q <= mth_pkg::MTH_ST_FETCH;
                    end else if (op == mth_pkg::MTH_OP_WAIT) begin
                        pc_q    <= link.opt_in0 ? pc_skip : pc_inc;
                        state_q <= mth_pkg::MTH_ST_FETCH;
                    end else if (!is_move) begin
                        pc_q    <= pc_inc;
                        state_q <= mth_pkg::MTH_ST_FETCH;
                    end else if (issue) begin
                        if (rep_q > 8'h01) begin
                            rep_q <= rep_q - 8'h01;
                        end else if (aux_en) begin
                            state_q <= mth_pkg::MTH_ST_MOVE;
                        end else begin
                            pc_q    <= pc_inc;
                            state_q <= mth_pkg::MTH_ST_FETCH;
                        end
                    end
                end
                mth_pkg::MTH_ST_MOVE: begin
                    if (move_done) begin
                        aux_q      <= 1'b1;
                        aux_code_q <= code;
                        state_q    <= mth_pkg::MTH_ST_AUX;
                    end
                end
                mth_pkg::MTH_ST_AUX: begin
                    if (link.aux_reset) begin
                        aux_q   <= 1'b0;
                        pc_q    <= pc_inc;
                        state_q <= mth_pkg::MTH_ST_FETCH;
                    end
                end
                default: state_q <= mth_pkg::MTH_ST_IDLE;
            endcase
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            move_start_q <= 1'b0;
            move_kind_q  <= mth_pkg::MTH_OP_END;
            move_tgt_q   <= `MTH_RST_WORD;
            prev_tgt_q   <= `MTH_RST_WORD;
            gain_set_q   <= 1'b0;
            gain_axis_q  <= 4'h0;
            gain_pct_q   <= 8'h00;
            armed_q      <= 1'b0;
            thr_q        <= `MTH_RST_WORD;
            ntf_num_q    <= `MTH_RST_WORD;
            notify_q     <= 1'b0;
        end else if (ce) begin
            move_start_q <= issue;
            gain_set_q   <= (state_q == mth_pkg::MTH_ST_EXEC) && (op == mth_pkg::MTH_OP_PARAM);
            notify_q     <= armed_q && ($signed(present_pos) >= $signed(thr_q));
            if (issue) begin
                move_kind_q <= op;
                move_tgt_q  <= tgt;
                prev_tgt_q  <= tgt;
            end
            if ((state_q == mth_pkg::MTH_ST_EXEC) && (op == mth_pkg::MTH_OP_PARAM)) begin
                gain_axis_q <= code[15:12];
                gain_pct_q  <= code[7:0];
            end
            // a later notify block replaces one that has not fired yet
            if (issue && ntf_en) begin
                armed_q   <= 1'b1;
                thr_q     <= prev_tgt_q + stop_q;
                ntf_num_q <= code;
            end else if (armed_q && ($signed(present_pos) >= $signed(thr_q))) begin
                armed_q <= 1'b0;
            end
        end
    end
    assign move_start      = move_start_q;
    assign move_kind       = move_kind_q;
    assign move_target     = move_tgt_q;
    assign gain_set        = gain_set_q;
    assign gain_axis       = gain_axis_q;
    assign gain_pct        = gain_pct_q;
    assign auto_mode       = {ctl_q[3][`MTH_B_AUTO], ctl_q[2][`MTH_B_AUTO],
                              ctl_q[1][`MTH_B_AUTO], ctl_q[0][`MTH_B_AUTO]};
    assign link.rd_data    = rd_data_q;
    assign link.busy       = state_q != mth_pkg::MTH_ST_IDLE;
    assign link.task_id    = task_q;
    assign link.aux_strobe = aux_q;
    assign link.aux_code   = aux_code_q;
    assign link.notify     = notify_q;
    assign link.notify_num = ntf_num_q;
endmodule

// *** core/mth_host.sv ***
`timescale 1ns/10ps
`include "mth_regs.svh"
module mth_host #(
    parameter int AXES = 4
) (
    input  wire logic            pclk,
    input  wire logic            presetn,
    input  wire logic            ce,
    input  wire logic [7:0]      paddr,
    input  wire logic            psel,
    input  wire logic            penable,
    input  wire logic            pwrite,
    input  wire logic [31:0]     pwdata,
    output logic [31:0]          prdata,
    output logic                 pready,
    output logic                 pslverr,
    input  wire logic [AXES-1:0] servo_locked,
    output logic                 irq,
    output logic                 notify_valid,
    output logic [15:0]          notify_num,
    mth_link_if.host             link
);

    logic [4:0]          laddr_q;
    logic                wr_en_q;
    logic [15:0]         wdata_q;
    logic                aux_rst_q;
    logic                opt_q;
    logic [`MTH_I_W-1:0] stat_q;
    logic [`MTH_I_W-1:0] mask_q;
    logic                aux_prev_q;
    logic                busy_prev_q;
    logic [15:0]         ntf_num_q;
    logic                ntf_v_q;
    logic [31:0]         prdata_q;
    logic                pready_q;
    logic                pslverr_q;
    logic                irq_q;

    wire setup     = psel & ~penable;
    wire wr        = psel & penable & pready_q & pwrite;
    wire hit_addr  = paddr == `MTH_A_LINK_ADDR;
    wire hit_data  = paddr == `MTH_A_LINK_DATA;
    wire hit_stat  = paddr == `MTH_A_STATUS;
    wire hit_ack   = paddr == `MTH_A_AUX_ACK;
    wire hit_opt   = paddr == `MTH_A_OPT_IN;
    wire hit_istat = paddr == `MTH_A_IRQ_STAT;
    wire hit_mask  = paddr == `MTH_A_IRQ_MASK;
    wire hit_ntf   = paddr == `MTH_A_NOTIFY;
    wire mapped    = hit_addr | hit_data | hit_stat | hit_ack |
                     hit_opt | hit_istat | hit_mask | hit_ntf;

    // a start on a task control word is stripped unless every axis is locked
    wire is_ctl    = (laddr_q >= `MTH_W_TASK_FIRST) && (laddr_q <= `MTH_W_TASK_LAST) && laddr_q[0];
    wire refused   = wr & hit_data & is_ctl & pwdata[`MTH_B_START] & ~(&servo_locked);
    wire [15:0] start_clr = 16'(1) << `MTH_B_START;
    wire [15:0] wdata_d   = refused ? (pwdata[15:0] & ~start_clr) : pwdata[15:0];

    wire [`MTH_I_W-1:0] ev;
    assign ev[`MTH_I_AUX]     = link.aux_strobe & ~aux_prev_q;
    assign ev[`MTH_I_NOTIFY]  = link.notify;
    assign ev[`MTH_I_REFUSED] = refused;
    assign ev[`MTH_I_DONE]    = busy_prev_q & ~link.busy;
    wire [`MTH_I_W-1:0] clr    = (wr & hit_istat) ? pwdata[`MTH_I_W-1:0] : '0;
    // an event in the clearing cycle survives the clear
    wire [`MTH_I_W-1:0] stat_d = (stat_q & ~clr) | ev;

    wire [31:0] status_w = {12'h000, link.aux_code, link.task_id, link.busy, link.aux_strobe};
    wire [31:0] rd_mux   = hit_addr  ? {27'h0000000, laddr_q} :
                           hit_data  ? {16'h0000, link.rd_data} :
                           hit_stat  ? status_w :
                           hit_opt   ? {31'h00000000, opt_q} :
                           hit_istat ? {28'h0000000, stat_q} :
                           hit_mask  ? {28'h0000000, mask_q} :
                           hit_ntf   ? {16'h0000, ntf_num_q} : 32'h00000000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q  <= 32'h00000000;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end else if (ce) begin
            pready_q  <= setup;
            pslverr_q <= setup & ~mapped;
            if (setup) begin
                prdata_q <= rd_mux;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            laddr_q   <= 5'h00;
            wr_en_q   <= 1'b0;
            wdata_q   <= `MTH_RST_WORD;
            aux_rst_q <= 1'b0;
            opt_q     <= 1'b0;
            mask_q    <= '0;
        end else if (ce) begin
            wr_en_q   <= wr & hit_data;
            aux_rst_q <= wr & hit_ack & pwdata[0];
            if (wr & hit_addr) begin
                laddr_q <= pwdata[4:0];
            end
            if (wr & hit_data) begin
                wdata_q <= wdata_d;
            end
            if (wr & hit_opt) begin
                opt_q <= pwdata[0];
            end
            if (wr & hit_mask) begin
                mask_q <= pwdata[`MTH_I_W-1:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_q      <= '0;
            irq_q       <= 1'b0;
            aux_prev_q  <= 1'b0;
            busy_prev_q <= 1'b0;
            ntf_num_q   <= `MTH_RST_WORD;
            ntf_v_q     <= 1'b0;
        end else if (ce) begin
            stat_q      <= stat_d;
            irq_q       <= |(stat_d & mask_q);
            aux_prev_q  <= link.aux_strobe;
            busy_prev_q <= link.busy;
            ntf_v_q     <= link.notify;
            if (link.notify) begin
                ntf_num_q <= link.notify_num;
            end
        end
    end

    assign prdata       = prdata_q;
    assign pready       = pready_q;
    assign pslverr      = pslverr_q;
    assign irq          = irq_q;
    assign notify_valid = ntf_v_q;
    assign notify_num   = ntf_num_q;
    assign link.wr_en     = wr_en_q;
    assign link.addr      = laddr_q;
    assign link.wr_data   = wdata_q;
    assign link.aux_reset = aux_rst_q;
    assign link.opt_in0   = opt_q;

endmodule

// *** sim/mth_sva.sv ***
`timescale 1ns/10ps
module mth_sva (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        wr_en,
    input wire logic [15:0] wr_data,
    input wire logic        busy,
    input wire logic [1:0]  task_id,
    input wire logic        aux_strobe,
    input wire logic [15:0] aux_code,
    input wire logic        aux_reset,
    input wire logic        notify
);
    // recent control writes carrying the start bit; the word address is not visible here
    logic [3:0] hist_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) hist_q <= 4'h0;
        else hist_q <= {hist_q[2:0], wr_en & wr_data[2]};
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_hold; aux_strobe && !aux_reset; endsequence
    sequence s_ack; aux_strobe && aux_reset; endsequence
    property p_wr_pulse; wr_en |-> !aux_reset ##1 !(wr_en || aux_reset); endproperty
    a_wr_pulse: assert property (p_wr_pulse) else $error("link write too long");
    property p_ack_pulse; aux_reset |=> !aux_reset; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("aux reset too long");
    property p_ntf_pulse; notify |=> !notify; endproperty
    a_ntf_pulse: assert property (p_ntf_pulse) else $error("notify too long");
    property p_aux_hold; s_hold |=> aux_strobe && $stable(aux_code); endproperty
    a_aux_hold: assert property (p_aux_hold) else $error("aux code dropped");
    property p_aux_drop; s_ack |-> ##[1:2] !aux_strobe; endproperty
    a_aux_drop: assert property (p_aux_drop) else $error("aux code not released");
    property p_aux_busy; aux_strobe |-> busy; endproperty
    a_aux_busy: assert property (p_aux_busy) else $error("aux code while idle");
    property p_start; $rose(busy) |-> |hist_q; endproperty
    a_start: assert property (p_start) else $error("run without start write");
    property p_owner; busy ##1 busy |-> $stable(task_id); endproperty
    a_owner: assert property (p_owner) else $error("task changed in run");
endmodule

// *** sim/motion_task_host_control_tb.sv ***
`timescale 1ns/10ps
`include "mth_regs.svh"
module motion_task_host_control_tb;
    logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, nv, err;
    logic              prog_we, move_ready, move_done, move_start, gain_set;
    logic [7:0]        paddr, prog_addr, gain_pct;
    logic [31:0]       pwdata, prdata, prog_wdata, rd;
    logic [15:0]       notify_num, present_pos, move_target, c1;
    logic [3:0]        servo_locked, gain_axis, auto_mode;
    logic [2:0]        dq;
    logic [19:0]       mq[$];
    mth_pkg::mth_op_e  move_kind;
    integer            seed, fails, checked, cyc, moves, nts;
    mth_link_if link ();
    mth_host i_mth_host (.pclk(pclk), .presetn(presetn), .ce(1'b1), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .servo_locked(servo_locked), .irq(irq), .notify_valid(nv),
        .notify_num(notify_num), .link(link));
    mth_device i_mth_device (.pclk(pclk), .presetn(presetn), .ce(1'b1), .link(link),
        .prog_we(prog_we), .prog_addr(prog_addr), .prog_wdata(prog_wdata),
        .move_ready(move_ready), .move_done(move_done), .present_pos(present_pos),
        .move_start(move_start), .move_kind(move_kind), .move_target(move_target),
        .gain_set(gain_set), .gain_axis(gain_axis), .gain_pct(gain_pct), .auto_mode(auto_mode));
    mth_sva i_mth_sva (.pclk(pclk), .presetn(presetn), .wr_en(link.wr_en),
        .wr_data(link.wr_data), .busy(link.busy), .task_id(link.task_id),
        .aux_strobe(link.aux_strobe), .aux_code(link.aux_code), .aux_reset(link.aux_reset),
        .notify(link.notify));
    task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    // all changes follow a rising edge; pready and read data are taken at the completing edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task linkw(input logic [4:0] a, input logic [15:0] d);
        apb(1'b1, `MTH_A_LINK_ADDR, {27'h0, a});
        apb(1'b1, `MTH_A_LINK_DATA, {16'h0, d});
    endtask
    task start(input logic [4:0] c);
        linkw(c, 16'h0002);
        linkw(c, 16'h0082);
        linkw(c, 16'h0086);
    endtask
    task stat_wait(input int b, input logic v);
        do apb(1'b0, `MTH_A_STATUS, 32'h0); while (rd[b] !== v);
    endtask
    task pw(input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        prog_we <= 1'b1;
        prog_addr <= a;
        prog_wdata <= d;
    endtask
    task tally_and_finish;
        $display("counts: checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // move engine answers a finished move four cycles after each start
    always @(posedge pclk) begin
        move_ready <= 1'($random(seed));
        dq <= {dq[1:0], move_start};
        move_done <= dq[2];
        cyc++;
        if (nv === 1'b1) nts++;
        if (gain_set === 1'b1) chk({gain_axis, gain_pct}, 12'h33C, "gain");
        if (move_start === 1'b1) begin
            moves++;
            chk({move_kind, move_target}, mq.pop_front(), "move");
        end
        if (cyc == 30000) begin
            fails++;
            tally_and_finish;
        end
    end
    initial begin
        presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; prog_we = 0;
        prog_addr = 0; prog_wdata = 0; move_ready = 0; move_done = 0; present_pos = 16'd64;
        servo_locked = 4'hF; dq = 0; seed = 58624; fails = 0; checked = 0; cyc = 0;
        moves = 0; nts = 0;
        c1 = 16'($random(seed));
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        pw(8'h10, {4'h1, 1'b1, 1'b0, 8'h00, 2'b00, c1});
        pw(8'h11, {4'h3, 1'b0, 1'b0, 8'h03, 2'b01, 16'h0000});
        pw(8'h12, {4'h1, 1'b1, 1'b1, 8'h00, 2'b00, 16'h0064});
        pw(8'h13, 32'h0);
        pw(8'h20, {4'h4, 28'h0});
        pw(8'h21, {4'h5, 28'h0});
        pw(8'h22, {4'h6, 12'h0, 16'h303C});
        pw(8'h23, {4'h1, 28'h0});
        pw(8'h24, 32'h0);
        @(posedge pclk) prog_we <= 1'b0;
        apb(1'b0, 8'h40, 32'h0);
        chk({31'h0, err}, 32'h1, "unmapped err");
        chk(rd, 32'h0, "unmapped data");
        $display("test reset done");
        apb(1'b1, `MTH_A_IRQ_MASK, 32'hF);
        linkw(5'h10, 16'd40);
        linkw(5'h11, 16'd60);
        linkw(5'h12, 16'd5);
        linkw(5'h04, 16'h0001);
        mq = '{{4'h1, 16'd40}, {4'h3, 16'd60}, {4'h3, 16'd60}, {4'h3, 16'd60}, {4'h1, 16'd40}};
        start(5'h05);
        stat_wait(0, 1'b1);
        chk(rd[19:0], {c1, 4'h7}, "status aux");
        apb(1'b0, `MTH_A_LINK_DATA, 32'h0);
        chk(rd, 32'h86, "ctl readback");
        chk({31'h0, irq}, 32'h1, "irq");
        apb(1'b1, `MTH_A_IRQ_STAT, 32'h1);
        apb(1'b0, `MTH_A_IRQ_STAT, 32'h0);
        chk({rd[30:0], irq}, 32'h0, "irq clear");
        apb(1'b1, `MTH_A_AUX_ACK, 32'h1);
        stat_wait(0, 1'b1);
        chk(rd[19:0], 20'h00647, "second aux");
        chk(nts, 0, "early notify");
        present_pos <= 16'd65;
        repeat (4) @(posedge pclk);
        chk(nts, 1, "notify");
        apb(1'b0, `MTH_A_NOTIFY, 32'h0);
        chk(rd, 32'd100, "notify num");
        apb(1'b1, `MTH_A_AUX_ACK, 32'h1);
        stat_wait(1, 1'b0);
        chk(moves, 5, "moves");
        apb(1'b0, `MTH_A_IRQ_STAT, 32'h0);
        chk(rd[3:0], 4'hB, "irq stat");
        linkw(5'h05, 16'h0086);
        repeat (2) @(posedge pclk);
        apb(1'b0, `MTH_A_STATUS, 32'h0);
        chk(rd[1], 1'b0, "held start");
        $display("test run done");
        apb(1'b1, `MTH_A_IRQ_STAT, 32'hF);
        servo_locked <= 4'h7;
        linkw(5'h02, 16'h0002);
        start(5'h03);
        apb(1'b0, `MTH_A_IRQ_STAT, 32'h0);
        chk(rd[3:0], 4'h4, "refused");
        servo_locked <= 4'hF;
        linkw(5'h03, 16'h0000);
        linkw(5'h03, 16'h0080);
        linkw(5'h03, 16'h0084);
        repeat (2) @(posedge pclk);
        apb(1'b0, `MTH_A_STATUS, 32'h0);
        chk(rd[1], 1'b0, "manual start");
        $display("test refuse done");
        mq.push_back({4'h1, 16'd40});
        start(5'h03);
        repeat (30) @(posedge pclk);
        apb(1'b0, `MTH_A_STATUS, 32'h0);
        chk({rd[3:0], 4'(moves)}, 8'h25, "wait loop");
        chk(auto_mode, 4'h3, "auto mode");
        apb(1'b1, `MTH_A_OPT_IN, 32'h1);
        stat_wait(1, 1'b0);
        chk({moves[15:0], 16'(mq.size())}, 32'h00060000, "after wait");
        $display("test wait done");
        tally_and_finish;
    end
endmodule
